// ### pmc_map.vh
// Purpose: constants for the power mode controller (offsets, fields, resets, timing)
// Assumes: one 20 MHz clock standing in for the oscillator; APB register access
// Notes:   register byte address is four times the register index
`ifndef PMC_MAP_VH
`define PMC_MAP_VH

// register indices and byte addresses
`define PMC_PWRCTL_IDX    8'h87
`define PMC_PWRCTL_ADDR   12'h21C
`define PMC_STAT_IDX      8'h88
`define PMC_STAT_ADDR     12'h220

// power control fields
`define PMC_B_SLEEP       0
`define PMC_B_OSCSTOP     1
`define PMC_B_FLAG0       2
`define PMC_B_FLAG1       3
`define PMC_B_BAUD2       7
`define PMC_PWRCTL_RST    8'h00
`define PMC_PWRCTL_WMASK  8'h8F

// status fields
`define PMC_S_IDLE        0
`define PMC_S_PDOWN       1
`define PMC_S_ONCE        2
`define PMC_S_RAMINH      3
`define PMC_S_INTRST      4

// timing in oscillator periods
`define PMC_MC_OSC        4'd12
`define PMC_S5P2_PH       4'd9
`define PMC_RST_LAG_OSC   5'd19

`endif

// ### pmc_phase.v
// Purpose: machine cycle phase counter and reset pin sampler
// Assumes: i_run low freezes the phase count, as when the oscillator stops
// Notes:   synchroniser runs on every clock so a stopped oscillator can still see reset
`timescale 1ns/100ps
`include "pmc_map.vh"
module pmc_phase (
	// clock and reset
	input  wire       i_clk,
	input  wire       i_rst_n,
	// control
	input  wire       i_run,
	input  wire       i_rst_pin,
	// phase and sampled reset
	output wire       o_s1p1,
	output wire       o_s5p2,
	output wire       o_rst_lvl,
	output reg        o_rst_smp
);
	reg  [3:0] ph_r;
	reg        sync1_r;
	reg        sync2_r;

	assign o_s1p1    = i_run && (ph_r == 4'h0);
	assign o_s5p2    = i_run && (ph_r == `PMC_S5P2_PH);
	assign o_rst_lvl = sync2_r;

	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ph_r      <= 4'h0;
			sync1_r   <= 1'b0;
			sync2_r   <= 1'b0;
			o_rst_smp <= 1'b0;
		end else begin
			// pin is asynchronous to the core clock
			sync1_r <= i_rst_pin;
			sync2_r <= sync1_r;
			if (i_run) begin
				ph_r <= (ph_r == `PMC_MC_OSC - 4'h1) ? 4'h0 : ph_r + 4'h1;
			end
			if (o_s5p2) begin
				o_rst_smp <= sync2_r;
			end
		end
	end
endmodule // pmc_phase

// ### pmc_top.v
// Purpose: power mode controller: idle, power-down, emulation mode, reset sampling
// Assumes: CPU flags the last cycle of each instruction; interrupt logic flags an enabled request
// Notes:   clocks are modelled as one-cycle-grained enables, never as gated clock nets
`timescale 1ns/100ps
`include "pmc_map.vh"
module pmc_top (
	// clock and reset
	input  wire        i_clk,
	input  wire        i_rst_n,
	// apb slave
	input  wire        i_psel,
	input  wire        i_penable,
	input  wire        i_pwrite,
	input  wire [11:0] i_paddr,
	input  wire [31:0] i_pwdata,
	output wire        o_pready,
	output wire        o_pslverr,
	output reg  [31:0] o_prdata,
	// pins
	input  wire        i_rst_pin,
	input  wire        i_ale_pin,
	input  wire        i_fetch_pin,
	// cpu and interrupt logic
	input  wire        i_instr_last,
	input  wire        i_irq_enabled,
	input  wire        i_t1_baud,
	input  wire [1:0]  i_serial_mode,
	// clock enables
	output reg         o_osc_run,
	output reg         o_cpu_clk_en,
	output wire        o_periph_clk_en,
	// core control
	output reg         o_int_reset,
	output reg         o_ram_inhibit,
	output reg         o_irq_wake,
	output wire        o_baud_double,
	// pin control
	output wire        o_port_hold,
	output wire        o_strobe_hold_hi,
	output wire        o_strobe_hold_lo,
	output wire        o_p0_float,
	output wire        o_weak_pullup
);
	localparam [1:0] ST_RUN   = 2'b00;
	localparam [1:0] ST_IDLE  = 2'b01;
	localparam [1:0] ST_PDOWN = 2'b10;
	localparam [1:0] ST_ONCE  = 2'b11;

	reg  [1:0] st_r;
	reg  [1:0] st_nxt;
	reg        sleep_r;
	reg        oscstop_r;
	reg        flag0_r;
	reg        flag1_r;
	reg        baud2_r;
	reg        idle_r;
	reg        idle_d_r;
	reg        wake_d_r;
	reg  [4:0] lag_r;
	reg        smp_d_r;

	wire       s1p1;
	wire       s5p2;
	wire       rst_lvl;
	wire       rst_smp;
	wire       acc;
	wire       wr;
	wire       wr_pwrctl;
	wire       hit_pwrctl;
	wire       hit_stat;
	wire [7:0] pwrctl_rd;
	wire [7:0] stat_rd;
	wire       wake;
	wire       idle_go;

	function is_addr;
		input [11:0] a;
		input [11:0] b;
		begin
			is_addr = (a == b);
		end
	endfunction

	pmc_phase u_phase (
		.i_clk     (i_clk),
		.i_rst_n   (i_rst_n),
		.i_run     (o_osc_run),
		.i_rst_pin (i_rst_pin),
		.o_s1p1    (s1p1),
		.o_s5p2    (s5p2),
		.o_rst_lvl (rst_lvl),
		.o_rst_smp (rst_smp)
	);

	// apb: zero wait states, unmapped addresses answer with an error
	assign acc       = i_psel && i_penable;
	assign wr        = acc && i_pwrite;
	assign hit_pwrctl = is_addr(i_paddr, `PMC_PWRCTL_ADDR);
	assign hit_stat   = is_addr(i_paddr, `PMC_STAT_ADDR);
	assign wr_pwrctl  = wr && hit_pwrctl;
	assign o_pready   = 1'b1;
	assign o_pslverr  = acc && !hit_pwrctl && !hit_stat;

	// reserved bits read as zero
	assign pwrctl_rd = {baud2_r, 3'b000, flag1_r, flag0_r, oscstop_r, sleep_r};
	assign stat_rd = {3'b000, o_int_reset, o_ram_inhibit, st_r == ST_ONCE,
	                  st_r == ST_PDOWN, idle_r};

	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_prdata <= 32'h0000_0000;
		end else if (i_psel && !i_penable && !i_pwrite) begin
			if (is_addr(i_paddr, `PMC_PWRCTL_ADDR)) begin
				o_prdata <= {24'h00_0000, pwrctl_rd};
			end else if (is_addr(i_paddr, `PMC_STAT_ADDR)) begin
				o_prdata <= {24'h00_0000, stat_rd};
			end else begin
				o_prdata <= 32'h0000_0000;
			end
		end
	end

	// interrupt wake only counts while the CPU is actually idle
	assign wake = idle_r && i_irq_enabled;
	// idle starts on a machine cycle boundary, so the CPU gate can fall at the same edge
	assign idle_go = sleep_r && !oscstop_r && i_instr_last && s1p1 && (st_r == ST_RUN) &&
	                 !i_rst_pin && !o_int_reset && !wr_pwrctl && !wake;

	// sleep bit: pin clears it directly, without waiting for the clock
	always @(posedge i_clk or negedge i_rst_n or posedge i_rst_pin) begin
		if (!i_rst_n) begin
			sleep_r <= 1'b0;
			idle_r  <= 1'b0;
		end else if (i_rst_pin) begin
			sleep_r <= 1'b0;
			idle_r  <= 1'b0;
		end else if (o_int_reset) begin
			sleep_r <= 1'b0;
			idle_r  <= 1'b0;
		end else if (wr_pwrctl) begin
			sleep_r <= i_pwdata[`PMC_B_SLEEP];
			idle_r  <= 1'b0;
		end else if (wake) begin
			sleep_r <= 1'b0;
			idle_r  <= 1'b0;
		end else if (idle_go) begin
			idle_r  <= 1'b1;
		end
	end

	// remaining fields, reinitialised by the internal reset
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			oscstop_r <= 1'b0;
			flag0_r   <= 1'b0;
			flag1_r   <= 1'b0;
			baud2_r   <= 1'b0;
		end else if (o_int_reset) begin
			oscstop_r <= 1'b0;
			flag0_r   <= 1'b0;
			flag1_r   <= 1'b0;
			baud2_r   <= 1'b0;
		end else if (wr_pwrctl) begin
			oscstop_r <= i_pwdata[`PMC_B_OSCSTOP];
			flag0_r   <= i_pwdata[`PMC_B_FLAG0];
			flag1_r   <= i_pwdata[`PMC_B_FLAG1];
			baud2_r   <= i_pwdata[`PMC_B_BAUD2];
		end else if (st_r == ST_PDOWN && rst_lvl) begin
			oscstop_r <= 1'b0;
		end
	end

	// baud doubling only applies with timer 1 as source and modes 1..3
	assign o_baud_double = baud2_r && i_t1_baud && (i_serial_mode != 2'b00);

	// mode sequencer
	always @* begin
		st_nxt = st_r;
		case (st_r)
			ST_RUN: begin
				if (oscstop_r && i_instr_last && s1p1 && !o_int_reset) begin
					st_nxt = ST_PDOWN;
				end else if (idle_r) begin
					st_nxt = ST_IDLE;
				end
			end
			ST_IDLE: begin
				if (oscstop_r) begin
					st_nxt = ST_PDOWN;
				end else if (!idle_r) begin
					st_nxt = ST_RUN;
				end
			end
			ST_PDOWN: begin
				// no interrupt path: only the reset pin restarts the oscillator
				if (rst_lvl) begin
					st_nxt = ST_RUN;
				end
			end
			ST_ONCE: begin
				if (o_int_reset && i_ale_pin) begin
					st_nxt = ST_RUN;
				end
			end
			default: begin
				st_nxt = ST_RUN;
			end
		endcase
		// emulation entry is judged at the S5P2 one machine cycle after the sampled reset falls
		if (smp_d_r && !rst_smp && s5p2 && !i_ale_pin && i_fetch_pin) begin
			st_nxt = ST_ONCE;
		end
	end

	// internal reset follows the sampled pin after a fixed lag
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_r        <= ST_RUN;
			lag_r       <= 5'd0;
			o_int_reset <= 1'b0;
			smp_d_r     <= 1'b0;
		end else begin
			st_r <= st_nxt;
			if (s5p2) begin
				smp_d_r <= rst_smp;
			end
			if (!rst_smp) begin
				lag_r       <= 5'd0;
				o_int_reset <= 1'b0;
			end else if (lag_r != `PMC_RST_LAG_OSC) begin
				lag_r <= lag_r + 5'd1;
			end else begin
				o_int_reset <= 1'b1;
			end
		end
	end

	// RAM is fenced between a reset-pin idle exit and internal reset take-over
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			idle_d_r      <= 1'b0;
			wake_d_r      <= 1'b0;
			o_ram_inhibit <= 1'b0;
			o_irq_wake    <= 1'b0;
		end else begin
			idle_d_r   <= idle_r;
			wake_d_r   <= wake;
			o_irq_wake <= wake;
			if (o_int_reset) begin
				o_ram_inhibit <= 1'b0;
			end else if (idle_d_r && !idle_r && !wake_d_r && !wr_pwrctl) begin
				o_ram_inhibit <= 1'b1;
			end
		end
	end

	// oscillator and clock enables; the CPU gate only moves on a cycle boundary, except that it reopens as soon as power-down ends
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_osc_run    <= 1'b1;
			o_cpu_clk_en <= 1'b1;
		end else begin
			o_osc_run <= (st_nxt != ST_PDOWN);
			if (st_nxt == ST_PDOWN) begin
				o_cpu_clk_en <= 1'b0;
			end else if (idle_go) begin
				o_cpu_clk_en <= 1'b0;
			end else if (s1p1 || (st_r == ST_PDOWN)) begin
				o_cpu_clk_en <= !idle_r;
			end
		end
	end

	// peripherals keep running in idle, stop with the oscillator
	assign o_periph_clk_en  = o_osc_run;

	// pin behaviour per mode; CPU registers hold because its enable is low
	assign o_port_hold      = (st_r == ST_IDLE) || (st_r == ST_PDOWN);
	assign o_strobe_hold_hi = (st_r == ST_IDLE);
	assign o_strobe_hold_lo = (st_r == ST_PDOWN);
	assign o_p0_float       = (st_r == ST_ONCE);
	assign o_weak_pullup    = (st_r == ST_ONCE);
endmodule // pmc_top

// ### pmc_top_props.sv
// Purpose: assertions on the power mode controller ports
// Assumes: far side holds the reset pin much longer than a machine cycle
// Notes:   a pin-high run counter bounds reset timing without the phase count
`timescale 1ns/100ps
module pmc_chk (
	// clock and reset
	input wire i_clk,
	input wire i_rst_n,
	// causes
	input wire i_rst_pin,
	input wire i_irq_enabled,
	// watched outputs
	input wire o_osc_run,
	input wire o_cpu_clk_en,
	input wire o_int_reset,
	input wire o_irq_wake,
	input wire o_port_hold,
	input wire o_strobe_hold_hi,
	input wire o_strobe_hold_lo,
	input wire o_p0_float,
	input wire o_weak_pullup
);
	default clocking dc @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	reg [5:0] run_r;
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			run_r <= 6'h00;
		else
			run_r <= i_rst_pin ? run_r + {5'h00, run_r != 6'h3F} : 6'h00;
	end
	sequence s_wake; ##[1:4] o_irq_wake ##1 !o_irq_wake; endsequence
	property p_idle; o_strobe_hold_hi |-> o_osc_run && !o_cpu_clk_en && o_port_hold; endproperty
	a_idle: assert property (p_idle) else $error("idle");
	property p_pd; o_strobe_hold_lo[*2] |-> !o_osc_run && !o_cpu_clk_en && !o_strobe_hold_hi; endproperty
	a_pd: assert property (p_pd) else $error("power down");
	property p_pd_end; $fell(o_strobe_hold_lo) |-> $past(run_r) != 6'h00; endproperty
	a_pd_end: assert property (p_pd_end) else $error("power down left");
	// the mode state follows the cleared sleep state one edge later
	property p_rst_idle; i_rst_pin |=> !o_strobe_hold_hi; endproperty
	a_rst_idle: assert property (p_rst_idle) else $error("idle kept");
	// the pin sample comes once a machine cycle, so the lag is bounded, not fixed
	property p_int_rst; run_r == 6'h30 |-> o_int_reset; endproperty
	a_int_rst: assert property (p_int_rst) else $error("no reset");
	property p_wake; $rose(i_irq_enabled) && o_strobe_hold_hi |-> s_wake; endproperty
	a_wake: assert property (p_wake) else $error("wake");
	property p_resume; $rose(o_irq_wake) |-> ##[0:13] o_cpu_clk_en; endproperty
	a_resume: assert property (p_resume) else $error("resume");
	property p_emu; o_p0_float |-> o_weak_pullup && o_osc_run; endproperty
	a_emu: assert property (p_emu) else $error("emulation");
endmodule // pmc_chk
bind pmc_top pmc_chk u_chk (.*);

// ### pmc_far.sv
// Purpose: far side model: instruction ends, interrupt source, reset and strobe pins
// Assumes: bench asks for events by one-cycle requests
// Notes:   slow mode ends instructions five apart, coprime to the machine cycle
`timescale 1ns/100ps
module pmc_far (
	// clock and reset
	input  wire i_clk,
	input  wire i_rst_n,
	// requests and feedback
	input  wire i_slow,
	input  wire i_irq_req,
	input  wire i_rst_go,
	input  wire i_emu,
	input  wire i_wake,
	input  wire i_int_reset,
	// controller inputs
	output reg  o_instr_last,
	output reg  o_irq,
	output reg  o_rst_pin,
	output wire o_ale,
	output wire o_fetch
);
	reg [6:0] hold_r;
	reg [2:0] div_r;
	assign o_fetch = 1'b1;
	assign o_ale = !i_emu;
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			{hold_r, div_r, o_instr_last, o_irq, o_rst_pin} <= 13'h0000;
		end else begin
			div_r <= (div_r == 3'h4) ? 3'h0 : div_r + 3'h1;
			o_instr_last <= !i_slow || div_r == 3'h4;
			o_irq <= i_irq_req || (o_irq && !i_wake && !i_int_reset);
			// 60 cycles covers two machine cycles and an oscillator restart
			hold_r <= i_rst_go ? 7'h3C : hold_r - {6'h00, hold_r != 7'h00};
			o_rst_pin <= i_rst_go || hold_r > 7'h01;
		end
	end
endmodule // pmc_far

// ### tb_power_mode_control.sv
// Purpose: self-checking bench for the power mode controller
// Assumes: APB slave answers when it likes; far-side model drives cpu and pins
// Notes:   random traffic keeps both mode bits clear so the core never sleeps by accident
`timescale 1ns/100ps
`include "pmc_map.vh"
module tb_power_mode_control;
	reg         i_clk, i_rst_n, i_psel, i_penable, i_pwrite, i_t1_baud, slow, irq_req, rst_go, emu, perr;
	reg  [11:0] i_paddr;
	reg  [31:0] i_pwdata, q;
	reg  [1:0]  i_serial_mode;
	reg  [7:0]  d;
	wire        o_pready, o_pslverr, i_rst_pin, i_ale_pin, i_fetch_pin, i_instr_last, i_irq_enabled, o_baud_double;
	wire        o_osc_run, o_cpu_clk_en, o_periph_clk_en, o_int_reset, o_ram_inhibit, o_irq_wake, o_port_hold;
	wire        o_strobe_hold_hi, o_strobe_hold_lo, o_p0_float, o_weak_pullup;
	wire [31:0] o_prdata;
	integer     errors, total_checks, seed, k, n, cyc;
	pmc_top uut (.*);
	pmc_far u_far (.i_clk, .i_rst_n, .i_slow(slow), .i_irq_req(irq_req), .i_rst_go(rst_go), .i_emu(emu),
		.i_wake(o_irq_wake), .i_int_reset(o_int_reset), .o_instr_last(i_instr_last), .o_irq(i_irq_enabled),
		.o_rst_pin(i_rst_pin), .o_ale(i_ale_pin), .o_fetch(i_fetch_pin));
	initial begin
		i_clk = 1'b0;
		forever #25 i_clk = !i_clk;
	end
	task tally_and_finish;
		begin
			$display("checks %0d errors %0d", total_checks, errors);
			if (errors == 0 && total_checks > 0)
				$display("TB: PASS");
			else
				$display("TB: FAIL");
			$finish;
		end
	endtask
	always @(posedge i_clk) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			errors = errors + 1;
			tally_and_finish;
		end
	end
	task chk(input [31:0] seen, input [31:0] exp, input string what);
		begin
			total_checks = total_checks + 1;
			if (seen !== exp) begin
				errors = errors + 1;
				$display("ERROR %s expected %h seen %h", what, exp, seen);
			end
		end
	endtask
	task apb(input wr, input [11:0] a, input [7:0] wd);
		begin
			@(posedge i_clk);
			i_psel <= 1'b1;
			i_pwrite <= wr;
			i_paddr <= a;
			i_pwdata <= {24'h000000, wd};
			@(posedge i_clk);
			i_penable <= 1'b1;
			@(posedge i_clk);
			while (o_pready !== 1'b1)
				@(posedge i_clk);
			q = o_prdata;
			perr = o_pslverr;
			i_psel <= 1'b0;
			i_penable <= 1'b0;
		end
	endtask
	task rd(input [11:0] a, input [31:0] e, input string what);
		begin
			apb(1'b0, a, 8'h00);
			chk(q, e, what);
		end
	endtask
	function sig(input integer s);
		case (s)
			0: sig = o_strobe_hold_hi;
			1: sig = o_strobe_hold_lo;
			2: sig = o_cpu_clk_en;
			3: sig = o_int_reset;
			4: sig = o_ram_inhibit;
			5: sig = o_p0_float;
			default: sig = o_osc_run;
		endcase
	endfunction
	// bounded wait; a miss shows up in the compare that follows
	task wait_on(input integer s, input v);
		for (n = 0; n < 200 && sig(s) !== v; n = n + 1)
			@(posedge i_clk);
	endtask
	task kick;
		begin
			rst_go <= 1'b1;
			@(posedge i_clk);
			rst_go <= 1'b0;
		end
	endtask
	task irq;
		begin
			irq_req <= 1'b1;
			@(posedge i_clk);
			irq_req <= 1'b0;
		end
	endtask
	function exp_baud(input b7, input t1, input [1:0] m);
		exp_baud = b7 & t1 & (m != 2'b00);
	endfunction
	initial begin
		seed = 42;
		{errors, total_checks, cyc} = 0;
		{i_rst_n, i_psel, i_penable, i_pwrite, i_t1_baud, slow, irq_req, rst_go, emu} = 9'h000;
		i_paddr = 12'h000;
		i_pwdata = 32'h00000000;
		i_serial_mode = 2'b00;
		repeat (16) @(posedge i_clk);
		i_rst_n <= 1'b1;
		rd(`PMC_PWRCTL_ADDR, 32'h00000000, "power control reset");
		apb(1'b1, 12'h3F0, 8'hFF);
		chk(perr, 1'b1, "unmapped");
		for (k = 0; k < 24; k = k + 1) begin
			d = (k == 0) ? 8'h8C : $random(seed) & 8'h8C;
			i_t1_baud <= $random(seed);
			i_serial_mode <= $random(seed);
			apb(1'b1, `PMC_PWRCTL_ADDR, d);
			rd(`PMC_PWRCTL_ADDR, {24'h000000, d}, "power control flags");
			chk(o_baud_double, exp_baud(d[7], i_t1_baud, i_serial_mode), "baud");
		end
		slow <= 1'b1;
		apb(1'b1, `PMC_PWRCTL_ADDR, 8'h05);
		wait_on(0, 1'b1);
		chk({o_osc_run, o_periph_clk_en, o_cpu_clk_en, o_port_hold}, 4'hD, "idle");
		rd(`PMC_STAT_ADDR, 32'h00000001, "idle status");
		irq;
		wait_on(2, 1'b1);
		rd(`PMC_PWRCTL_ADDR, 32'h00000004, "wake");
		apb(1'b1, `PMC_PWRCTL_ADDR, 8'h0D);
		wait_on(0, 1'b1);
		kick;
		wait_on(4, 1'b1);
		chk({o_ram_inhibit, o_strobe_hold_hi}, 2'h2, "reset ends idle");
		wait_on(3, 1'b1);
		wait_on(3, 1'b0);
		rd(`PMC_PWRCTL_ADDR, 32'h00000000, "power control cleared");
		slow <= 1'b0;
		apb(1'b1, `PMC_PWRCTL_ADDR, 8'h03);
		wait_on(1, 1'b1);
		chk({o_osc_run, o_cpu_clk_en, o_strobe_hold_hi, o_port_hold}, 4'h1, "power down");
		irq;
		repeat (40) @(posedge i_clk);
		chk(o_strobe_hold_lo, 1'b1, "power down kept");
		kick;
		wait_on(6, 1'b1);
		wait_on(3, 1'b1);
		wait_on(3, 1'b0);
		rd(`PMC_PWRCTL_ADDR, 32'h00000000, "power control after power down");
		emu <= 1'b1;
		kick;
		wait_on(3, 1'b1);
		wait_on(5, 1'b1);
		chk({o_p0_float, o_weak_pullup, o_osc_run}, 3'h7, "emulation");
		emu <= 1'b0;
		kick;
		wait_on(5, 1'b0);
		chk(o_p0_float, 1'b0, "emulation left");
		tally_and_finish;
	end
endmodule // tb_power_mode_control
